// file: shared/or_decode_pkg.sv
/*
 * Shared constants, types and decode functions for the no-operation and byte OR
 * execution block and its internal data memory.
 * Assumes one core clock, a fetch unit that hands over code bytes in order, and
 * an on-chip special function register space above the internal RAM.
 */
package or_decode_pkg;

   // Opcodes and opcode prefixes.
   localparam logic [7:0] OPC_NOP = 8'h00;
   localparam logic [4:0] OPC_OR_RN_HI = 5'h09;
   localparam logic [6:0] OPC_OR_IND_HI = 7'h23;
   localparam logic [7:0] OPC_OR_IMM = 8'h44;
   localparam logic [7:0] OPC_OR_DIR = 8'h45;
   localparam logic [7:0] OPC_OR_DA = 8'h42;
   localparam logic [7:0] OPC_OR_DI = 8'h43;

   // Address map of the direct space.
   localparam logic [7:0] ACC_ADDR = 8'he0;
   localparam logic [1:0] PORT_ADDR_HI = 2'h2;
   localparam logic [3:0] PORT_ADDR_LO = 4'h0;
   localparam int PORT_IDX_LSB = 4;
   localparam int RAM_DEPTH = 256;
   localparam int RAM_AW = 8;

   // Reset values.
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] PORT_RST = 8'hff;
   localparam logic [15:0] PC_RST = 16'h0000;

   // One machine cycle spans this many core clocks.
   localparam int MC_CLKS = 3;

   typedef enum logic [0:0] {S_FETCH, S_EXEC} fsm_e;
   typedef enum logic [2:0] {F_NOP, F_RN, F_DIR, F_IND, F_IMM, F_DA, F_DI, F_BAD} form_e;

   typedef logic [3:0][7:0] port_bank_t;

   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] data;
   } sfr_wr_s;

   function automatic form_e decode_form(input logic [7:0] opc);
      form_e f;
      f = F_BAD;
      if (opc == OPC_NOP) f = F_NOP;
      else if (opc[7:3] == OPC_OR_RN_HI) f = F_RN;
      else if (opc[7:1] == OPC_OR_IND_HI) f = F_IND;
      else if (opc == OPC_OR_DIR) f = F_DIR;
      else if (opc == OPC_OR_IMM) f = F_IMM;
      else if (opc == OPC_OR_DA) f = F_DA;
      else if (opc == OPC_OR_DI) f = F_DI;
      return f;
   endfunction : decode_form

   function automatic logic [1:0] instr_len(input logic [7:0] opc);
      form_e f;
      f = decode_form(opc);
      if (f == F_DI) return 2'h3;
      if (f == F_DIR || f == F_IMM || f == F_DA) return 2'h2;
      return 2'h1;
   endfunction : instr_len

   function automatic logic [1:0] instr_cycles(input logic [7:0] opc);
      return (decode_form(opc) == F_DI) ? 2'h2 : 2'h1;
   endfunction : instr_cycles

   function automatic logic is_port(input logic [7:0] a);
      return (a[7:6] == PORT_ADDR_HI) && (a[3:0] == PORT_ADDR_LO);
   endfunction : is_port

endpackage : or_decode_pkg

// file: hdl/or_data_ram.sv
/*
 * Internal data memory of the core: working registers, pointer targets and
 * directly addressed RAM, one synchronous port with registered read data.
 * Assumes the owner presents address and write data from its own clock domain.
 */
`timescale 1ns/1ps
module or_data_ram
   import or_decode_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_we,
   input wire logic [RAM_AW-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);

   logic [7:0] mem [RAM_DEPTH];

   // Contents are not cleared by reset, as in a real RAM macro.
   always_ff @(posedge i_clk) begin
      if (i_ce && i_we) begin
         mem[i_addr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         o_rdata <= mem[i_addr];
      end
   end

endmodule : or_data_ram

// file: hdl/nop_and_byte_or_decode.sv
/*
 * Execution of the no-operation instruction and the six byte OR forms:
 * code byte intake, operand fetch, OR, write back and program counter advance.
 * Assumes code bytes arrive in order from fetch logic on the core clock, the
 * register bank select comes from the status word, and port pins are asynchronous.
 */
// How it works
// RULE_01: No-operation only advances the program counter.
// RULE_02: Byte OR stores result, flags stay untouched.
// RULE_03: Exactly six OR operand forms are decoded.
// RULE_04: Port destination reads latch, not pins.
// RULE_05: Register form: one byte, one cycle.
// RULE_06: Direct into accumulator: two bytes, one cycle.
// RULE_07: Indirect form via pointer register, one cycle.
// RULE_08: Immediate into accumulator: two bytes, one cycle.
// RULE_09: Immediate into direct: three bytes, two cycles.
// RULE_10: Accumulator into direct: two bytes, one cycle.
`timescale 1ns/1ps
module nop_and_byte_or_decode
   import or_decode_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_code_valid,
   input wire logic [7:0] i_code,
   input wire logic [1:0] i_bank,
   input wire port_bank_t i_port_pins,
   input wire logic [7:0] i_sfr_rdata,
   output logic o_code_ready,
   output logic [15:0] o_pc,
   output logic [7:0] o_acc,
   output port_bank_t o_port_latch,
   output sfr_wr_s o_sfr_wr,
   output logic o_instr_done,
   output logic o_illegal
);

   typedef struct packed {
      fsm_e state;
      logic [7:0] opc;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [1:0] nb;
      logic [2:0] ph;
      logic [7:0] opnd;
      logic [7:0] acc;
      port_bank_t latch;
      port_bank_t pin_s1;
      port_bank_t pin_s2;
      logic [15:0] pc;
      sfr_wr_s sfr;
      logic done;
      logic illegal;
   } core_s;

   localparam core_s CORE_RST = '{state: S_FETCH, acc: ACC_RST, latch: {4{PORT_RST}},
                                  pc: PC_RST, default: '0};

   core_s st_r;
   core_s st_nxt;
   form_e form;
   logic [2:0] last_ph;
   logic rmw;
   logic [1:0] pidx;
   logic [7:0] rd_val;
   logic [7:0] src;
   logic [7:0] res;
   logic [1:0] len;
   logic mem_we;
   logic [7:0] mem_addr;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata;

   or_data_ram u_ram (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .i_we(mem_we),
      .i_addr(mem_addr),
      .i_wdata(mem_wdata),
      .o_rdata(mem_rdata)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      st_nxt.illegal = 1'b0;
      st_nxt.sfr.we = 1'b0;
      st_nxt.pin_s1 = i_port_pins;
      st_nxt.pin_s2 = st_r.pin_s1;
      form = decode_form(st_r.opc);
      last_ph = 3'(int'(instr_cycles(st_r.opc)) * MC_CLKS - 1);
      rmw = (form == F_DA) || (form == F_DI);
      pidx = st_r.b1[PORT_IDX_LSB +: 2];
      res = 8'h00;
      mem_we = 1'b0;
      mem_wdata = 8'h00;
      len = instr_len((st_r.nb == 2'h0) ? i_code : st_r.opc);
      // RULE_04: latch for write-back
      // A plain read of a port sees the pins; a read that will be written back
      // sees the latch, so a pin held low by a load never clears a set bit.
      if (!st_r.b1[7]) begin
         rd_val = mem_rdata;
      end else if (is_port(st_r.b1)) begin
         rd_val = rmw ? st_r.latch[pidx] : st_r.pin_s2[pidx];
      end else if (st_r.b1 == ACC_ADDR) begin
         rd_val = st_r.acc;
      end else begin
         rd_val = i_sfr_rdata;
      end
      // RULE_05: working register address
      // RULE_07: pointer then target
      if (form == F_RN) begin
         mem_addr = {3'h0, i_bank, st_r.opc[2:0]};
      end else if (form == F_IND) begin
         mem_addr = (st_r.ph == 3'h0) ? {3'h0, i_bank, 2'h0, st_r.opc[0]} : mem_rdata;
      end else begin
         mem_addr = st_r.b1;
      end
      // RULE_08: immediate source byte
      if (form == F_RN || form == F_DIR) begin
         src = st_r.opnd;
      end else if (form == F_IND) begin
         src = mem_rdata;
      end else begin
         src = st_r.b1;
      end
      unique case (st_r.state)
         S_FETCH: begin
            if (i_code_valid) begin
               unique case (st_r.nb)
                  2'h0: st_nxt.opc = i_code;
                  2'h1: st_nxt.b1 = i_code;
                  default: st_nxt.b2 = i_code;
               endcase
               // RULE_06: length from opcode
               if (2'(st_r.nb + 2'h1) == len) begin
                  st_nxt.state = S_EXEC;
                  st_nxt.ph = 3'h0;
                  st_nxt.nb = 2'h0;
               end else begin
                  st_nxt.nb = 2'(st_r.nb + 2'h1);
               end
            end
         end
         S_EXEC: begin
            st_nxt.ph = 3'(st_r.ph + 3'h1);
            if (st_r.ph == 3'h1) begin
               st_nxt.opnd = (form == F_RN) ? mem_rdata : rd_val;
            end
            if (st_r.ph == last_ph) begin
               st_nxt.state = S_FETCH;
               st_nxt.done = 1'b1;
               // RULE_01: only the counter moves
               st_nxt.pc = 16'(st_r.pc + {14'h0, instr_len(st_r.opc)});
               // RULE_02: OR into destination
               // RULE_03: six forms, rest refused
               if (form == F_RN || form == F_DIR || form == F_IND || form == F_IMM) begin
                  st_nxt.acc = st_r.acc | src;
               end else if (rmw) begin
                  // RULE_09: mask into direct
                  // RULE_10: accumulator into direct
                  res = st_r.opnd | ((form == F_DA) ? st_r.acc : st_r.b2);
                  if (!st_r.b1[7]) begin
                     mem_we = 1'b1;
                     mem_wdata = res;
                  end else if (is_port(st_r.b1)) begin
                     st_nxt.latch[pidx] = res;
                  end else if (st_r.b1 == ACC_ADDR) begin
                     st_nxt.acc = res;
                  end else begin
                     st_nxt.sfr = '{we: 1'b1, addr: st_r.b1, data: res};
                  end
               end else if (form == F_BAD) begin
                  st_nxt.illegal = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_r <= CORE_RST;
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   assign o_code_ready = (st_r.state == S_FETCH);
   assign o_pc = st_r.pc;
   assign o_acc = st_r.acc;
   assign o_port_latch = st_r.latch;
   assign o_sfr_wr = st_r.sfr;
   assign o_instr_done = st_r.done;
   assign o_illegal = st_r.illegal;

   // Helper count of execute clocks, read only by the checks below.
   logic [2:0] xcnt_r;
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         xcnt_r <= 3'h0;
      end else if (i_ce) begin
         xcnt_r <= (st_r.state == S_EXEC) ? 3'(xcnt_r + 3'h1) : 3'h0;
      end
   end

   property p_nop_quiet; // RULE_01
      @(posedge i_clk) disable iff (!i_nrst || !i_ce)
      (st_r.state == S_EXEC && form == F_NOP) |-> !mem_we && !st_nxt.sfr.we
         && st_nxt.acc == st_r.acc && st_nxt.latch == st_r.latch;
   endproperty
   a_nop_quiet: assert property (p_nop_quiet) else $error("nop changed state");

   property p_nop_pc; // RULE_01
      @(posedge i_clk) disable iff (!i_nrst || !i_ce)
      ($rose(st_r.done) && st_r.opc == OPC_NOP) |-> st_r.pc == 16'($past(st_r.pc) + 16'h1)
         && $past(xcnt_r) == 3'h2;
   endproperty
   a_nop_pc: assert property (p_nop_pc) else $error("nop pc or timing wrong");

   property p_or_acc; // RULE_02
      @(posedge i_clk) disable iff (!i_nrst || !i_ce)
      ($rose(st_r.done) && form inside {F_RN, F_DIR, F_IND, F_IMM})
         |-> (st_r.acc & $past(st_r.acc)) == $past(st_r.acc);
   endproperty
   a_or_acc: assert property (p_or_acc) else $error("or lost accumulator bits");

   property p_forms; // RULE_03
      @(posedge i_clk) disable iff (!i_nrst || !i_ce)
      $rose(st_r.done) |-> st_r.illegal == !(st_r.opc == 8'h00 || st_r.opc[7:3] == 5'h09
         || (st_r.opc >= 8'h42 && st_r.opc <= 8'h47));
   endproperty
   a_forms: assert property (p_forms) else $error("form decode wrong");

   property p_port_latch; // RULE_04
      @(posedge i_clk) disable iff (!i_nrst || !i_ce)
      (st_r.state == S_EXEC && st_r.ph == last_ph && rmw && is_port(st_r.b1))
         |=> (st_r.latch[pidx] & $past(st_r.latch[pidx])) == $past(st_r.latch[pidx]);
   endproperty
   a_port_latch: assert property (p_port_latch) else $error("port latch bits lost");

   property p_rn_timing; // RULE_05
      @(posedge i_clk) disable iff (!i_nrst || !i_ce)
      ($rose(st_r.done) && form == F_RN) |-> $past(xcnt_r) == 3'h2
         && st_r.pc == 16'($past(st_r.pc) + 16'h1);
   endproperty
   a_rn_timing: assert property (p_rn_timing) else $error("register form timing wrong");

   property p_dir_timing; // RULE_06
      @(posedge i_clk) disable iff (!i_nrst || !i_ce)
      ($rose(st_r.done) && form == F_DIR) |-> $past(xcnt_r) == 3'h2
         && st_r.pc == 16'($past(st_r.pc) + 16'h2);
   endproperty
   a_dir_timing: assert property (p_dir_timing) else $error("direct form timing wrong");

   property p_ind_addr; // RULE_07
      @(posedge i_clk) disable iff (!i_nrst || !i_ce)
      (st_r.state == S_EXEC && st_r.ph == 3'h0 && form == F_IND)
         |-> mem_addr == {3'h0, i_bank, 2'h0, st_r.opc[0]} ##1 mem_addr == mem_rdata;
   endproperty
   a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong");

   property p_imm_timing; // RULE_08
      @(posedge i_clk) disable iff (!i_nrst || !i_ce)
      ($rose(st_r.done) && form == F_IMM) |-> $past(xcnt_r) == 3'h2
         && st_r.acc == ($past(st_r.acc) | st_r.b1);
   endproperty
   a_imm_timing: assert property (p_imm_timing) else $error("immediate form wrong");

   property p_di_timing; // RULE_09
      @(posedge i_clk) disable iff (!i_nrst || !i_ce)
      ($rose(st_r.done) && form == F_DI) |-> $past(xcnt_r) == 3'h5
         && st_r.pc == 16'($past(st_r.pc) + 16'h3);
   endproperty
   a_di_timing: assert property (p_di_timing) else $error("immediate direct timing wrong");

   property p_da_timing; // RULE_10
      @(posedge i_clk) disable iff (!i_nrst || !i_ce)
      ($rose(st_r.done) && form == F_DA) |-> $past(xcnt_r) == 3'h2
         && st_r.pc == 16'($past(st_r.pc) + 16'h2);
   endproperty
   a_da_timing: assert property (p_da_timing) else $error("accumulator direct timing wrong");

endmodule : nop_and_byte_or_decode

// file: bench/nop_and_byte_or_decode_bench.sv
/*
 * Self-checking bench for the no-operation and byte OR execution block.
 * Assumes the block's own assertions guard timing inside the design, and that
 * internal RAM starts unknown, so RAM operands are only built by ORing in ff.
 */
`timescale 1ns/1ps
module nop_and_byte_or_decode_bench;
   import or_decode_pkg::*;

   logic i_clk;
   logic i_nrst;
   logic i_ce;
   logic i_code_valid;
   logic [7:0] i_code;
   logic [1:0] i_bank;
   port_bank_t i_port_pins;
   logic [7:0] i_sfr_rdata;
   logic o_code_ready;
   logic [15:0] o_pc;
   logic [7:0] o_acc;
   port_bank_t o_port_latch;
   sfr_wr_s o_sfr_wr;
   logic o_instr_done;
   logic o_illegal;
   int error_cnt = 0;
   int checks_done = 0;
   int sfr_cnt = 0;
   sfr_wr_s sfr_last;

   nop_and_byte_or_decode i_dut (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_code_valid(i_code_valid),
      .i_code(i_code), .i_bank(i_bank), .i_port_pins(i_port_pins),
      .i_sfr_rdata(i_sfr_rdata), .o_code_ready(o_code_ready), .o_pc(o_pc),
      .o_acc(o_acc), .o_port_latch(o_port_latch), .o_sfr_wr(o_sfr_wr),
      .o_instr_done(o_instr_done), .o_illegal(o_illegal)
   );

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic end_sim;
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   // Offers nb code bytes, then times execution until the done pulse.
   task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                      input int nb, input int ncyc, input logic bad);
      int n;
      logic [15:0] pc0;
      pc0 = o_pc;
      for (int k = 0; k < nb; k++) begin
         chk("ready", o_code_ready, 16'h0001);
         i_code_valid = 1'b1;
         i_code = (k == 0) ? b0 : ((k == 1) ? b1 : b2);
         @(negedge i_clk);
      end
      i_code_valid = 1'b0;
      n = 1;
      chk("busy ready", o_code_ready, 16'h0000);
      while (o_instr_done !== 1'b1 && n < 20) begin
         @(negedge i_clk);
         n++;
      end
      // The write pulse stands in the same cycle as done, so it is caught here.
      if (o_sfr_wr.we === 1'b1) begin
         sfr_cnt++;
         sfr_last = o_sfr_wr;
      end
      chk("clocks", 16'(n), 16'(1 + MC_CLKS * ncyc));
      chk("pc", o_pc, pc0 + 16'(nb));
      chk("illegal", o_illegal, 16'(bad));
   endtask : run

   task automatic t_reset;
      chk("pc rst", o_pc, 16'h0000);
      chk("acc rst", o_acc, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         chk("latch rst", o_port_latch[k], 16'h00ff);
      end
   endtask : t_reset

   task automatic t_nop;
      int c0;
      c0 = sfr_cnt;
      run(8'h00, 8'h00, 8'h00, 1, 1, 1'b0);
      chk("nop acc", o_acc, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         chk("nop latch", o_port_latch[k], 16'h00ff);
      end
      chk("nop wr", 16'(sfr_cnt), 16'(c0));
   endtask : t_nop

   task automatic t_acc_forms;
      run(8'h44, 8'h41, 8'h00, 2, 1, 1'b0);
      chk("imm acc", o_acc, 16'h0041);
      i_sfr_rdata = 8'h82;
      run(8'h45, 8'hf0, 8'h00, 2, 1, 1'b0);
      chk("dir acc", o_acc, 16'h00c3);
   endtask : t_acc_forms

   task automatic t_dest_direct;
      int c0;
      c0 = sfr_cnt;
      i_sfr_rdata = 8'h0c;
      run(8'h42, 8'hf0, 8'h00, 2, 1, 1'b0);
      chk("da count", 16'(sfr_cnt), 16'(c0 + 1));
      chk("da addr", sfr_last.addr, 16'h00f0);
      chk("da data", sfr_last.data, 16'h00cf);
      chk("da acc", o_acc, 16'h00c3);
      i_sfr_rdata = 8'h01;
      run(8'h43, 8'hf0, 8'h30, 3, 2, 1'b0);
      chk("di count", 16'(sfr_cnt), 16'(c0 + 2));
      chk("di addr", sfr_last.addr, 16'h00f0);
      chk("di data", sfr_last.data, 16'h0031);
   endtask : t_dest_direct

   // Pins low under a latch of ff: a pin read would leave 32 behind.
   task automatic t_port;
      int c0;
      c0 = sfr_cnt;
      i_port_pins = '0;
      repeat (3) @(negedge i_clk);
      run(8'h43, 8'h90, 8'h32, 3, 2, 1'b0);
      chk("port latch", o_port_latch[1], 16'h00ff);
      chk("port wr", 16'(sfr_cnt), 16'(c0));
      // A plain read of a port sees the pins, not the latch of ff.
      i_port_pins[2] = 8'h0c;
      repeat (3) @(negedge i_clk);
      run(8'h45, 8'ha0, 8'h00, 2, 1, 1'b0);
      chk("port pin read", o_acc, 16'h00cf);
   endtask : t_port

   task automatic t_illegal;
      logic [7:0] opc[5] = '{8'h3f, 8'h40, 8'h41, 8'h50, 8'h72};
      for (int k = 0; k < 5; k++) begin
         run(opc[k], 8'h00, 8'h00, 1, 1, 1'b1);
         chk("bad acc", o_acc, 16'h00cf);
      end
   endtask : t_illegal

   // Bank two register three sits at 13; a wrong bank reads unknown RAM.
   task automatic t_reg_ind;
      run(8'h43, 8'h13, 8'hff, 3, 2, 1'b0);
      i_bank = 2'h2;
      run(8'h4b, 8'h00, 8'h00, 1, 1, 1'b0);
      chk("rn acc", o_acc, 16'h00ff);
      for (int r = 0; r < 8; r++) begin
         run(8'h48 | 8'(r), 8'h00, 8'h00, 1, 1, 1'b0);
         chk("rn all", o_acc, 16'h00ff);
      end
      i_bank = 2'h0;
      run(8'h46, 8'h00, 8'h00, 1, 1, 1'b0);
      chk("ind0 acc", o_acc, 16'h00ff);
      run(8'h47, 8'h00, 8'h00, 1, 1, 1'b0);
      chk("ind1 acc", o_acc, 16'h00ff);
   endtask : t_reg_ind

   initial begin
      i_nrst = 1'b0;
      i_ce = 1'b1;
      i_code_valid = 1'b0;
      i_code = 8'h00;
      i_bank = 2'h0;
      i_port_pins = {4{8'h5a}};
      i_sfr_rdata = 8'h00;
      repeat (8) @(negedge i_clk);
      i_nrst = 1'b1;
      t_reset();
      t_nop();
      t_acc_forms();
      t_dest_direct();
      t_port();
      t_illegal();
      t_reg_ind();
      end_sim();
   end

   // The whole sequence needs well under a thousand clocks.
   initial begin
      #(20 * 4000);
      error_cnt++;
      $display("Error watchdog: expected end of tests, seen no end");
      end_sim();
   end

endmodule : nop_and_byte_or_decode_bench
